// >>> hw/slu_pkg.sv
// package: constants, types and decode helpers for the scalar logical and shift unit
//
// Overview of operation
// - 044 writes AND; zero designators give special results
// - 045 writes first AND NOT second operand
// - 046 writes XOR; equal nonzero designators clear result
// - 047 writes XNOR; equal nonzero designators give ones
// - 050 merges first operand under second's mask
// - 051 writes OR; both zero gives sign bit
// - logical ops issue in one, ready one later
// - logical issue held on busy, conflict, reservations
// - 052/054 shift left by immediate, zero fill
// - 053/055 shift right by 64 minus immediate
// - immediate shifts ready two periods after issue
// - 052/053 also hold on register zero reserved
// - 056/057 shift register pair by address count
// - zero partner designator uses zero partner value
// - equal nonzero designators rotate for counts up to 64
// - 056 left shift, upper half, clear above 127
// - 057 right shift, lower half, clear above 127
// - pair shifts hold on partner/count reserved; three periods
package slu_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [6:0] OP_AND = 7'h24;
    localparam logic [6:0] OP_ANDN = 7'h25;
    localparam logic [6:0] OP_XOR = 7'h26;
    localparam logic [6:0] OP_XNOR = 7'h27;
    localparam logic [6:0] OP_MERGE = 7'h28;
    localparam logic [6:0] OP_OR = 7'h29;
    localparam logic [6:0] OP_SHL_S0 = 7'h2a;
    localparam logic [6:0] OP_SHR_S0 = 7'h2b;
    localparam logic [6:0] OP_SHL = 7'h2c;
    localparam logic [6:0] OP_SHR = 7'h2d;
    localparam logic [6:0] OP_DSHL = 7'h2e;
    localparam logic [6:0] OP_DSHR = 7'h2f;

    // ----------------------------------------------------------------
    // data constants and timing
    // ----------------------------------------------------------------
    localparam logic [63:0] SIGN_BIT = 64'h8000_0000_0000_0000;
    localparam logic [6:0] WORD_BITS = 7'h40;
    localparam logic [23:0] DBL_MAX_CNT = 24'h00007f;
    localparam logic [23:0] DBL_ZERO_K_CNT = 24'h000001;
    localparam logic [7:0] RESV_RESET = 8'h00;
    localparam int LAT_LOG = 1;
    localparam int LAT_SH = 2;
    localparam int LAT_DBL = 3;
    localparam int NUM_STAGES = 3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {CLS_NONE, CLS_LOG, CLS_SH, CLS_DBL} slu_cls_e;

    typedef struct packed {
        logic [6:0] opcode;
        logic [2:0] i;
        logic [2:0] j;
        logic [2:0] k;
    } slu_iss_s;

    typedef struct packed {
        logic [63:0] si;
        logic [63:0] sj;
        logic [63:0] sk;
        logic [23:0] ak;
    } slu_opnd_s;

    typedef struct packed {
        logic valid;
        logic [2:0] addr;
        logic [63:0] data;
    } slu_wr_s;

    // which part of the unit executes an opcode
    function automatic slu_cls_e op_class(input logic [6:0] op);
        if (op >= OP_AND && op <= OP_OR)
            return CLS_LOG;
        else if (op >= OP_SHL_S0 && op <= OP_SHR)
            return CLS_SH;
        else if (op == OP_DSHL || op == OP_DSHR)
            return CLS_DBL;
        else
            return CLS_NONE;
    endfunction

endpackage

// >>> hw/slu_logic.sv
// combinational scalar logical functions
`timescale 1ns/1ps
module slu_logic (
    // instruction
    input wire logic [6:0] opcode,
    input wire logic [2:0] j,
    input wire logic [2:0] k,
    // operands
    input wire logic [63:0] si,
    input wire logic [63:0] sj,
    input wire logic [63:0] sk,
    // result
    output logic [63:0] res
);

    // ----------------------------------------------------------------
    // operand substitution
    // ----------------------------------------------------------------
    // designator zero reads as 0 (first) or sign bit only (second); every degenerate
    // case then falls out of the plain boolean form, so no per-case muxing is needed
    wire logic [63:0] a_op = (j == 3'h0) ? 64'h0 : sj;
    wire logic [63:0] b_op = (k == 3'h0) ? slu_pkg::SIGN_BIT : sk;

    // ----------------------------------------------------------------
    // function select
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (opcode)
            slu_pkg::OP_AND: res = a_op & b_op;
            slu_pkg::OP_ANDN: res = a_op & ~b_op;
            slu_pkg::OP_XOR: res = a_op ^ b_op;
            slu_pkg::OP_XNOR: res = ~(a_op ^ b_op);
            slu_pkg::OP_MERGE: res = (a_op & b_op) | (si & ~b_op);
            slu_pkg::OP_OR: res = a_op | b_op;
            default: res = 64'h0; // other opcodes never select this result
        endcase
    end

endmodule // slu_logic

// >>> hw/slu_shift.sv
// combinational scalar single and double shifts
`timescale 1ns/1ps
module slu_shift (
    // instruction
    input wire logic [6:0] opcode,
    input wire logic [2:0] i,
    input wire logic [2:0] j,
    input wire logic [2:0] k,
    // operands
    input wire logic [63:0] si,
    input wire logic [63:0] sj,
    input wire logic [23:0] ak,
    // result
    output logic [63:0] res,
    output logic [2:0] dest
);

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    wire logic [5:0] imm = {j, k};
    wire logic [6:0] right_amt = slu_pkg::WORD_BITS - {1'b0, imm};
    wire logic [23:0] dcnt = (k == 3'h0) ? slu_pkg::DBL_ZERO_K_CNT : ak;
    wire logic dbig = dcnt > slu_pkg::DBL_MAX_CNT;
    wire logic [63:0] partner = (j == 3'h0) ? 64'h0 : sj;

    // ----------------------------------------------------------------
    // shifters
    // ----------------------------------------------------------------
    // with i == j nonzero the pair holds the same word twice, so a 128-bit shift of it is a
    // rotate up to 64 and the reduced end-off shift beyond, without a separate path
    wire logic [127:0] dleft = {si, partner} << dcnt[6:0];
    wire logic [127:0] dright = {partner, si} >> dcnt[6:0];
    wire logic [63:0] sleft = si << imm;
    wire logic [63:0] sright = si >> right_amt;

    // result and destination select
    always_comb
    begin
        dest = i;
        unique case (opcode)
            slu_pkg::OP_SHL_S0:
            begin
                res = sleft;
                dest = 3'h0;
            end
            slu_pkg::OP_SHR_S0:
            begin
                res = sright;
                dest = 3'h0;
            end
            slu_pkg::OP_SHL: res = sleft;
            slu_pkg::OP_SHR: res = sright;
            slu_pkg::OP_DSHL: res = dbig ? 64'h0 : dleft[127:64];
            slu_pkg::OP_DSHR: res = dbig ? 64'h0 : dright[63:0];
            default: res = 64'h0; // other opcodes never select this result
        endcase
    end

endmodule // slu_shift

// >>> hw/slu_unit.sv
// scalar logical and shift unit: issue hold, reservations and result pipeline
`timescale 1ns/1ps
module slu_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // issue request and operands
    input wire logic iss_valid,
    input wire slu_pkg::slu_iss_s iss,
    input wire slu_pkg::slu_opnd_s opnd,
    // issue conditions from the rest of the processor
    input wire logic blk_xfer_busy,
    input wire logic exchange_busy,
    input wire logic s_access_conflict,
    input wire logic [7:0] s_resv_ext,
    input wire logic [7:0] a_resv_ext,
    // issue answer
    output logic iss_taken_q,
    output logic iss_refused_q,
    // reservations held by this unit
    output logic [7:0] resv_q,
    // result write port to the scalar registers
    output slu_pkg::slu_wr_s wr_q
);

    // ----------------------------------------------------------------
    // datapaths
    // ----------------------------------------------------------------
    logic [63:0] log_res;
    logic [63:0] sh_res;
    logic [2:0] sh_dest;

    slu_logic u_logic (
        .opcode(iss.opcode),
        .j(iss.j),
        .k(iss.k),
        .si(opnd.si),
        .sj(opnd.sj),
        .sk(opnd.sk),
        .res(log_res)
    );

    slu_shift u_shift (
        .opcode(iss.opcode),
        .i(iss.i),
        .j(iss.j),
        .k(iss.k),
        .si(opnd.si),
        .sj(opnd.sj),
        .ak(opnd.ak),
        .res(sh_res),
        .dest(sh_dest)
    );

    // ----------------------------------------------------------------
    // issue hold
    // ----------------------------------------------------------------
    slu_pkg::slu_wr_s st_q [slu_pkg::NUM_STAGES];
    slu_pkg::slu_wr_s st_d [slu_pkg::NUM_STAGES];

    wire slu_pkg::slu_cls_e cls = slu_pkg::op_class(iss.opcode);
    wire logic is_log = cls == slu_pkg::CLS_LOG;
    wire logic is_sh = cls == slu_pkg::CLS_SH;
    wire logic is_dbl = cls == slu_pkg::CLS_DBL;
    wire logic [7:0] rsv_all = resv_q | s_resv_ext;
    wire logic to_s0 = iss.opcode == slu_pkg::OP_SHL_S0 || iss.opcode == slu_pkg::OP_SHR_S0;
    wire logic j_busy = iss.j != 3'h0 && rsv_all[iss.j];
    wire logic k_busy = iss.k != 3'h0 && rsv_all[iss.k];
    wire logic ak_busy = iss.k != 3'h0 && a_resv_ext[iss.k];
    // two results must never reach the write port in the same cycle, so an early
    // result is held off when a longer one already occupies the slot it would need
    wire logic slot1_busy = st_q[1].valid;
    wire logic slot2_busy = st_q[0].valid;
    // shared hold for every opcode of the unit
    wire logic hold_com = blk_xfer_busy | exchange_busy | s_access_conflict | rsv_all[iss.i];
    wire logic hold_log = is_log && (j_busy || k_busy || slot1_busy);
    wire logic hold_sh = is_sh && ((to_s0 && rsv_all[0]) || slot2_busy);
    wire logic hold_dbl = is_dbl && (j_busy || ak_busy);
    wire logic hold = hold_com | hold_log | hold_sh | hold_dbl;
    wire logic ours = iss_valid && cls != slu_pkg::CLS_NONE;
    wire logic take = ours && !hold;

    // ----------------------------------------------------------------
    // result entry and pipeline
    // ----------------------------------------------------------------
    // a result enters the stage that leaves it exactly its latency from the write port
    wire logic [1:0] ins_idx = is_log ? 2'(slu_pkg::NUM_STAGES - slu_pkg::LAT_LOG) :
                               is_sh ? 2'(slu_pkg::NUM_STAGES - slu_pkg::LAT_SH) :
                               2'(slu_pkg::NUM_STAGES - slu_pkg::LAT_DBL);
    wire slu_pkg::slu_wr_s new_res = '{valid: 1'b1,
                                       addr: is_log ? iss.i : sh_dest,
                                       data: is_log ? log_res : sh_res};

    genvar s;
    generate
        for (s = 0; s < slu_pkg::NUM_STAGES; s++)
        begin : g_stage
            if (s == 0)
            begin : g_head
                assign st_d[s] = (take && ins_idx == 2'(s)) ? new_res : '0;
            end
            else
            begin : g_body
                assign st_d[s] = (take && ins_idx == 2'(s)) ? new_res : st_q[s - 1];
            end

            // stage register
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    st_q[s] <= '0;
                else
                    st_q[s] <= st_d[s];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // reservations
    // ----------------------------------------------------------------
    // release in the write cycle, set on issue; set wins on a shared edge
    wire logic [7:0] resv_set = take ? (8'h01 << new_res.addr) : 8'h00;
    wire logic [7:0] resv_clr = st_q[2].valid ? (8'h01 << st_q[2].addr) : 8'h00;
    wire logic [7:0] resv_d = (resv_q & ~resv_clr) | resv_set;

    // reservation and answer registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            resv_q <= slu_pkg::RESV_RESET;
            iss_taken_q <= 1'b0;
            iss_refused_q <= 1'b0;
        end
        else
        begin
            resv_q <= resv_d;
            iss_taken_q <= take;
            iss_refused_q <= ours && hold;
        end
    end

    assign wr_q = st_q[2]; // straight from the last stage flop

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wire logic take_log = take && is_log;
    wire logic take_sh = take && is_sh;
    wire logic take_dbl = take && is_dbl;

    log_latency_a: assert property (take_log |=> wr_q.valid && wr_q.addr == $past(iss.i))
        else $error("logical result not written one period after issue");
    sh_latency_a: assert property (take_sh |-> ##2 wr_q.valid && wr_q.addr == $past(sh_dest, 2))
        else $error("shift result not written two periods after issue");
    dbl_latency_a: assert property (take_dbl |-> ##3 wr_q.valid && wr_q.addr == $past(iss.i, 3))
        else $error("pair shift result not written three periods after issue");
    blk_hold_a: assert property (ours && (blk_xfer_busy || exchange_busy) |=> iss_refused_q && !iss_taken_q)
        else $error("issue not held during block transfer or exchange");
    s0_hold_a: assert property (iss_valid && to_s0 && rsv_all[0] |=> !iss_taken_q)
        else $error("shift to register zero issued while it was reserved");
    and_copy_a: assert property (take_log && iss.opcode == slu_pkg::OP_AND && iss.j != 3'h0 && iss.j == iss.k
        |=> wr_q.data == $past(opnd.sj))
        else $error("and with equal designators did not copy first operand");
    xor_clear_a: assert property (take_log && iss.opcode == slu_pkg::OP_XOR && iss.j != 3'h0 && iss.j == iss.k
        |=> wr_q.data == 64'h0)
        else $error("xor with equal designators did not clear");
    or_sign_a: assert property (take_log && iss.opcode == slu_pkg::OP_OR && iss.j == 3'h0 && iss.k == 3'h0
        |=> wr_q.data == slu_pkg::SIGN_BIT)
        else $error("or with zero designators did not give the sign bit");
    dshl_clear_a: assert property (take_dbl && iss.k != 3'h0 && opnd.ak > slu_pkg::DBL_MAX_CNT
        |-> ##3 wr_q.data == 64'h0)
        else $error("pair shift beyond 127 did not clear");
    resv_set_a: assert property (take |=> resv_q[$past(new_res.addr)])
        else $error("destination reservation not set at issue");
    // a held destination can never be issued again before its write, so the release is never overridden
    resv_free_a: assert property (wr_q.valid |=> !resv_q[$past(wr_q.addr)])
        else $error("destination reservation not released after write");

    cover_log_c: cover property (take_log ##1 wr_q.valid);
    cover_rot_c: cover property (take_dbl && iss.i == iss.j && iss.i != 3'h0);
    cover_hold_c: cover property (ours && hold_log);
    cover_slot_c: cover property (take_dbl ##2 (ours && is_log && slot1_busy));

endmodule // slu_unit

// >>> tb/slu_regs_model.sv
// far-side model: scalar and address register files feeding the unit
`timescale 1ns/1ps
module slu_regs_model (
    // clock
    input wire logic clk,
    // designators of the presented request
    input wire slu_pkg::slu_iss_s iss,
    // result write from the unit
    input wire slu_pkg::slu_wr_s wr,
    // register contents to the unit
    output slu_pkg::slu_opnd_s opnd
);
    logic [63:0] s_q [8];
    logic [23:0] a_q [8];

    // raw reads: register zero is sent as is, substitution is the unit's job
    assign opnd = {s_q[iss.i], s_q[iss.j], s_q[iss.k], a_q[iss.k]};

    // a result lands at the edge that ends its write cycle
    always @(posedge clk)
    begin
        if (wr.valid)
            s_q[wr.addr] <= wr.data;
    end
endmodule // slu_regs_model

// >>> tb/scalar_logic_shift_unit_test.sv
// self-checking bench for the scalar logical and shift unit
`timescale 1ns/1ps
module scalar_logic_shift_unit_test;
    logic clk, rst_n, iss_valid, blk_xfer_busy, exchange_busy, s_access_conflict;
    logic iss_taken_q, iss_refused_q;
    logic [7:0] s_resv_ext, a_resv_ext, resv_q;
    slu_pkg::slu_iss_s iss;
    slu_pkg::slu_opnd_s opnd;
    slu_pkg::slu_wr_s wr_q;
    int num_errors = 0;
    int checks_done = 0;

    slu_unit dut (.clk(clk), .rst_n(rst_n), .iss_valid(iss_valid), .iss(iss), .opnd(opnd),
        .blk_xfer_busy(blk_xfer_busy), .exchange_busy(exchange_busy),
        .s_access_conflict(s_access_conflict), .s_resv_ext(s_resv_ext), .a_resv_ext(a_resv_ext),
        .iss_taken_q(iss_taken_q), .iss_refused_q(iss_refused_q), .resv_q(resv_q), .wr_q(wr_q));
    slu_regs_model m (.clk(clk), .iss(iss), .wr(wr_q), .opnd(opnd));

    // ----------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // the run needs well under 2000 cycles, so 20000 means a hang
    initial
    begin
        #160000;
        num_errors++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // expected result from the register contents before issue
    function automatic logic [63:0] ref_res(input logic [6:0] op, input logic [2:0] i, j, k);
        logic [63:0] a, b, c;
        logic [127:0] p;
        logic [23:0] n;
        a = (j == 3'h0) ? 64'h0 : m.s_q[j];
        b = (k == 3'h0) ? slu_pkg::SIGN_BIT : m.s_q[k];
        c = m.s_q[i];
        n = (k == 3'h0) ? 24'h000001 : m.a_q[k];
        case (op)
            7'h24: return a & b;
            7'h25: return a & ~b;
            7'h26: return a ^ b;
            7'h27: return ~(a ^ b);
            7'h28: return (a & b) | (c & ~b);
            7'h29: return a | b;
            7'h2a, 7'h2c: return c << {j, k};
            7'h2b, 7'h2d: return c >> (7'h40 - {1'b0, j, k});
            7'h2e: p = {c, a} << n;
            default: p = {a, c} >> n;
        endcase
        return (n > 24'h00007f) ? 64'h0 : ((op == 7'h2e) ? p[127:64] : p[63:0]);
    endfunction

    // one request followed to its write and the release of its reservation
    task automatic issue(input logic [6:0] op, input logic [2:0] i, j, k, input logic go);
        logic [63:0] want;
        logic [2:0] d;
        int lat;
        want = ref_res(op, i, j, k);
        d = (op == 7'h2a || op == 7'h2b) ? 3'h0 : i;
        lat = (op < 7'h2a) ? 1 : ((op < 7'h2e) ? 2 : 3);
        iss = {op, i, j, k};
        iss_valid = 1'b1;
        @(posedge clk);
        #1;
        iss_valid = 1'b0;
        chk("taken", go, iss_taken_q);
        chk("refused", !go, iss_refused_q);
        chk("reserved", go, resv_q[d]);
        repeat (lat - 1)
        begin
            @(posedge clk);
            #1;
        end
        chk("write", go, wr_q.valid);
        if (go)
        begin
            chk("addr", d, wr_q.addr);
            chk("data", want, wr_q.data);
        end
        @(posedge clk);
        #1;
        chk("released", 1'b0, resv_q[d]);
    endtask

    // one request under a given set of hold conditions
    task automatic hold_try(input logic [2:0] busy, input logic [7:0] sr, ar, input logic [6:0] op,
        input logic [2:0] i, j, k, input logic go);
        {blk_xfer_busy, exchange_busy, s_access_conflict} = busy;
        s_resv_ext = sr;
        a_resv_ext = ar;
        issue(op, i, j, k, go);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_logical();
        logic [2:0] js [5] = '{3'h2, 3'h3, 3'h0, 3'h4, 3'h0};
        logic [2:0] ks [5] = '{3'h5, 3'h3, 3'h6, 3'h0, 3'h0};
        for (int n = 0; n < 30; n++)
            issue(7'h24 + 7'(n / 5), 3'(n % 7 + 1), js[n % 5], ks[n % 5], 1'b1);
    endtask

    task automatic t_shift();
        logic [5:0] jk [4] = '{6'h00, 6'h01, 6'h2a, 6'h3f};
        for (int n = 0; n < 16; n++)
            issue(7'h2a + 7'(n / 4), 3'(n % 7 + 1), jk[n % 4][5:3], jk[n % 4][2:0], 1'b1);
    endtask

    // counts across the rotate, end-off and clear boundaries; partner must survive
    task automatic t_double();
        logic [23:0] cn [8] = '{24'h1, 24'h5, 24'h3f, 24'h40, 24'h41, 24'h7f, 24'h80, 24'hfffffe};
        logic [2:0] is [3] = '{3'h2, 3'h3, 3'h4};
        logic [2:0] jd [3] = '{3'h5, 3'h3, 3'h0};
        logic [63:0] keep;
        for (int n = 0; n < 48; n++)
        begin
            m.a_q[6] = cn[n % 8];
            keep = m.s_q[5];
            issue(7'h2e + 7'(n / 24), is[(n / 8) % 3], jd[(n / 8) % 3], 3'h6, 1'b1);
            chk("partner", keep, m.s_q[5]);
        end
        issue(7'h2e, 3'h2, 3'h5, 3'h0, 1'b1);
        issue(7'h2f, 3'h4, 3'h0, 3'h0, 1'b1);
    endtask

    task automatic t_hold();
        hold_try(3'h4, 8'h00, 8'h00, 7'h24, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h2, 8'h00, 8'h00, 7'h2c, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h1, 8'h00, 8'h00, 7'h2e, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h0, 8'h02, 8'h00, 7'h28, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h0, 8'h04, 8'h00, 7'h26, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h0, 8'h08, 8'h00, 7'h29, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h0, 8'h01, 8'h00, 7'h25, 3'h1, 3'h0, 3'h0, 1'b1);
        hold_try(3'h0, 8'h01, 8'h00, 7'h2b, 3'h1, 3'h2, 3'h3, 1'b0);
        hold_try(3'h0, 8'h01, 8'h00, 7'h2d, 3'h1, 3'h2, 3'h3, 1'b1);
        hold_try(3'h0, 8'h04, 8'h00, 7'h2f, 3'h1, 3'h2, 3'h6, 1'b0);
        hold_try(3'h0, 8'h00, 8'h40, 7'h2e, 3'h1, 3'h2, 3'h6, 1'b0);
        hold_try(3'h0, 8'h01, 8'h01, 7'h2e, 3'h1, 3'h0, 3'h0, 1'b1);
        // conditions lifted once at the end, so no input moves twice in one step
        {blk_xfer_busy, exchange_busy, s_access_conflict} = 3'h0;
        s_resv_ext = 8'h00;
        a_resv_ext = 8'h00;
    endtask

    // a dependent request right behind a pair shift must wait on its reservation
    task automatic t_chain();
        logic [63:0] want;
        m.a_q[6] = 24'h000005;
        want = ref_res(7'h2e, 3'h3, 3'h5, 3'h6);
        iss = {7'h2e, 3'h3, 3'h5, 3'h6};
        iss_valid = 1'b1;
        @(posedge clk);
        #1;
        iss = {7'h24, 3'h4, 3'h3, 3'h1};
        chk("chain taken", 1'b1, iss_taken_q);
        @(posedge clk);
        #1;
        iss_valid = 1'b0;
        chk("chain refused", 1'b1, iss_refused_q);
        @(posedge clk);
        #1;
        chk("chain data", want, wr_q.valid ? wr_q.data : ~want);
        @(posedge clk);
        #1;
    endtask

    // an opcode outside the unit must give no answer, no write and no reservation
    task automatic t_foreign();
        iss = {7'h00, 3'h1, 3'h2, 3'h3};
        iss_valid = 1'b1;
        @(posedge clk);
        #1;
        iss_valid = 1'b0;
        chk("foreign answer", 2'h0, {iss_taken_q, iss_refused_q});
        @(posedge clk);
        #1;
        chk("foreign effect", 9'h000, {wr_q.valid, resv_q});
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        rst_n = 1'b0;
        iss_valid = 1'b0;
        iss = '0;
        {blk_xfer_busy, exchange_busy, s_access_conflict} = 3'h0;
        s_resv_ext = 8'h00;
        a_resv_ext = 8'h00;
        for (int n = 0; n < 8; n++)
        begin
            m.s_q[n] = 64'hc3a5_0f96_e1d2_7b49 * (n + 3);
            m.a_q[n] = 24'h000003;
        end
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        chk("reset out", 3'h0, {iss_taken_q, iss_refused_q, wr_q.valid});
        chk("reset resv", 8'h00, resv_q);
        t_foreign();
        t_logical();
        t_shift();
        t_double();
        t_hold();
        t_chain();
        give_verdict();
    end
endmodule // scalar_logic_shift_unit_test
